// ### rxlt_host.sv
// Purpose: Two-wire bus host model
// Assumes: Pull-ups on both lines
// Notes:   Half period 10 clocks; data moves mid-low to avoid false START
`timescale 1ns/1ps
module rxlt_host (
  input  wire logic clk_sys,
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sda
);
  import rxlt_pkg::*;
  logic hostSda = 1'b1;
  initial scl = 1'b1;
  assign sda = hostSda & ~sdaOe;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start;
    wt(4);
    hostSda = 1'b1;
    wt(6);
    scl = 1'b1;
    wt(10);
    hostSda = 1'b0;
    wt(10);
    scl = 1'b0;
  endtask
  task automatic stop;
    wt(4);
    hostSda = 1'b0;
    wt(6);
    scl = 1'b1;
    wt(10);
    hostSda = 1'b1;
    wt(10);
  endtask
  // Nine bits, first bit most significant; a released bit reads the wire
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(4);
      hostSda = tx[i];
      wt(6);
      scl = 1'b1;
      wt(10);
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d, output logic ack);
    logic [8:0] r1, r2, r3;
    start();
    xfer({DEV_ADDR, 1'b0, 1'b1}, r1);
    xfer({off, 1'b1}, r2);
    xfer({d, 1'b1}, r3);
    stop();
    ack = !(r1[0] | r2[0] | r3[0]);
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({DEV_ADDR, 1'b0, 1'b1}, r);
    xfer({off, 1'b1}, r);
    start();
    xfer({DEV_ADDR, 1'b1, 1'b1}, r);
    xfer({8'hFF, 1'b1}, r);
    stop();
    d = r[8:1];
  endtask
endmodule

// ### rxlt_pkg.sv
// Purpose: Shared constants and carriers for the rx low threshold / ADC result slice
// Assumes: Two-wire serial bus with seven-bit device address, byte offsets
// Notes:   Offsets and reset values live here only
package rxlt_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h51;
  localparam logic [7:0] OFF_RX_HI_TH_HI = 8'h24;
  localparam logic [7:0] OFF_RX_HI_TH_LO = 8'h25;
  localparam logic [7:0] OFF_RX_LO_TH_HI = 8'h26;
  localparam logic [7:0] OFF_RX_LO_TH_LO = 8'h27;
  localparam logic [7:0] OFF_CHECKSUM    = 8'h5F;
  localparam logic [7:0] OFF_TEMP_HI     = 8'h60;
  localparam logic [7:0] OFF_TEMP_LO     = 8'h61;
  localparam logic [7:0] OFF_VOLT_HI     = 8'h62;
  localparam logic [7:0] OFF_VOLT_LO     = 8'h63;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_FIRST       = 3'h0;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } rxlt_pair_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] temp;
    logic [7:0] volt;
  } rxlt_adc_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_AACK  = 7'b000_0100,
    ST_WRX   = 7'b000_1000,
    ST_WACK  = 7'b001_0000,
    ST_RTX   = 7'b010_0000,
    ST_RACK  = 7'b100_0000
  } rxlt_state_t;
endpackage

// ### rxlt_regs.sv
// Purpose: Serial-bus register slice: rx low threshold, checksum, ADC results
// Assumes: Two-wire bus slave at fixed address; OEM unlock given by password logic
// Notes:   Nonvolatile storage modelled as reset-to-zero flops
`timescale 1ns/1ps
module rxlt_regs (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             sclIn,
  input  wire logic             sdaIn,
  output logic                  sdaOut,
  output logic                  sdaOe,
  input  wire logic             oemUnlocked,
  input  wire rxlt_pkg::rxlt_adc_t adcResult,
  input  wire logic [7:0]       rxPowerMeasuredHigh,
  output rxlt_pkg::rxlt_pair_t  rxPowerHighThreshold,
  output rxlt_pkg::rxlt_pair_t  rxPowerLowThreshold,
  output logic                  rxHighWarning,
  output logic                  rxLowWarning
);
  import rxlt_pkg::*;

  logic        sclLevel;
  logic        sdaLevel;
  logic        sclPrev;
  logic        sdaPrev;
  rxlt_state_t state;
  rxlt_state_t next_state;
  logic [7:0]  shiftReg;
  logic [7:0]  next_shiftReg;
  logic [2:0]  bitCount;
  logic [2:0]  next_bitCount;
  logic [7:0]  offset;
  logic [7:0]  next_offset;
  logic        haveOffset;
  logic        next_haveOffset;
  logic        isRead;
  logic        next_isRead;
  logic        drive;
  logic        next_drive;
  logic        startPending;
  logic        next_startPending;
  rxlt_pair_t  next_rxPowerHighThreshold;
  rxlt_pair_t  next_rxPowerLowThreshold;
  logic [7:0]  pageChecksum;
  logic [7:0]  next_pageChecksum;
  logic [7:0]  temperatureResultHigh;
  logic [7:0]  next_temperatureResultHigh;
  logic [7:0]  supplyVoltageResultHigh;
  logic [7:0]  next_supplyVoltageResultHigh;
  logic        next_rxHighWarning;
  logic        next_rxLowWarning;
  logic [7:0]  readByte;
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;
  logic        writeStrobe;

  rxlt_sync u_scl_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pinIn   (sclIn),
    .level   (sclLevel)
  );

  rxlt_sync u_sda_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pinIn   (sdaIn),
    .level   (sdaLevel)
  );

  assign sclRise   = sclLevel && !sclPrev;
  assign sclFall   = !sclLevel && sclPrev;
  assign startSeen = sclLevel && sclPrev && sdaPrev && !sdaLevel;
  assign stopSeen  = sclLevel && sclPrev && !sdaPrev && sdaLevel;
  // Open drain: only ever pull low
  assign sdaOut    = 1'b0;
  assign sdaOe     = drive;

  always_comb begin
    case (offset)
      OFF_RX_HI_TH_HI: readByte = rxPowerHighThreshold.hi;
      OFF_RX_HI_TH_LO: readByte = rxPowerHighThreshold.lo;
      OFF_RX_LO_TH_HI: readByte = rxPowerLowThreshold.hi;
      OFF_RX_LO_TH_LO: readByte = rxPowerLowThreshold.lo;
      OFF_CHECKSUM:    readByte = pageChecksum;
      OFF_TEMP_HI:     readByte = temperatureResultHigh;
      OFF_VOLT_HI:     readByte = supplyVoltageResultHigh;
      OFF_TEMP_LO:     readByte = ZERO_BYTE;
      OFF_VOLT_LO:     readByte = ZERO_BYTE;
      default:         readByte = ZERO_BYTE;
    endcase
  end

  // Serial protocol engine
  always_comb begin
    next_state      = state;
    next_shiftReg   = shiftReg;
    next_bitCount   = bitCount;
    next_offset     = offset;
    next_haveOffset = haveOffset;
    next_isRead     = isRead;
    next_drive      = drive;
    next_startPending = startPending;
    writeStrobe     = 1'b0;
    if (startSeen) begin
      next_state    = ST_ADDR;
      next_bitCount = BIT_LAST;
      next_drive    = 1'b0;
      next_startPending = 1'b1;
    end else if (stopSeen) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
      next_startPending = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_drive = 1'b0;
        end
        ST_ADDR, ST_WRX: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sdaLevel};
          end else if (sclFall && startPending) begin
            // Clock fall closing a START carries no bit
            next_startPending = 1'b0;
          end else if (sclFall) begin
            if (bitCount == BIT_FIRST) begin
              if (state == ST_ADDR) begin
                if (shiftReg[7:1] == DEV_ADDR) begin
                  next_isRead     = shiftReg[0];
                  next_haveOffset = 1'b0;
                  next_drive      = 1'b1;
                  next_state      = ST_AACK;
                end else begin
                  next_state = ST_IDLE;
                end
              end else begin
                next_drive = 1'b1;
                next_state = ST_WACK;
                if (haveOffset) begin
                  writeStrobe = 1'b1;
                  // Step only after a data byte, never the offset byte
                  next_offset = offset + 8'h01;
                end else begin
                  next_offset     = shiftReg;
                  next_haveOffset = 1'b1;
                end
              end
            end else begin
              next_bitCount = bitCount - 3'h1;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (sclFall) begin
            next_bitCount = BIT_LAST;
            if (state == ST_AACK && isRead) begin
              next_shiftReg = readByte;
              next_drive    = !readByte[7];
              next_state    = ST_RTX;
            end else begin
              next_drive = 1'b0;
              next_state = ST_WRX;
            end
          end
        end
        ST_RTX: begin
          if (sclFall) begin
            if (bitCount == BIT_FIRST) begin
              next_drive = 1'b0;
              next_state = ST_RACK;
            end else begin
              next_bitCount = bitCount - 3'h1;
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_drive    = !shiftReg[6];
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            next_offset = offset + 8'h01;
            // Master NACK ends the read
            if (sdaLevel) begin
              next_state = ST_IDLE;
            end
          end else if (sclFall) begin
            next_bitCount = BIT_LAST;
            next_shiftReg = readByte;
            next_drive    = !readByte[7];
            next_state    = ST_RTX;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // Register updates and comparisons
  always_comb begin
    next_rxPowerHighThreshold    = rxPowerHighThreshold;
    next_rxPowerLowThreshold     = rxPowerLowThreshold;
    next_pageChecksum            = pageChecksum;
    next_temperatureResultHigh   = temperatureResultHigh;
    next_supplyVoltageResultHigh = supplyVoltageResultHigh;
    if (writeStrobe) begin
      case (offset)
        OFF_RX_HI_TH_HI: next_rxPowerHighThreshold.hi = shiftReg;
        // Stored for the host; never compared
        OFF_RX_HI_TH_LO: next_rxPowerHighThreshold.lo = shiftReg;
        OFF_RX_LO_TH_HI: next_rxPowerLowThreshold.hi = shiftReg;
        OFF_RX_LO_TH_LO: next_rxPowerLowThreshold.lo = shiftReg;
        OFF_CHECKSUM: begin
          if (oemUnlocked) begin
            next_pageChecksum = shiftReg;
          end
        end
        default: begin
        end
      endcase
    end
    if (adcResult.valid) begin
      next_temperatureResultHigh   = adcResult.temp;
      next_supplyVoltageResultHigh = adcResult.volt;
    end
    next_rxHighWarning = rxPowerMeasuredHigh > rxPowerHighThreshold.hi;
    next_rxLowWarning  = rxPowerMeasuredHigh < rxPowerLowThreshold.hi;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state                   <= ST_IDLE;
      shiftReg                <= RESET_BYTE;
      bitCount                <= BIT_LAST;
      offset                  <= RESET_BYTE;
      haveOffset              <= 1'b0;
      isRead                  <= 1'b0;
      drive                   <= 1'b0;
      startPending            <= 1'b0;
      sclPrev                 <= 1'b1;
      sdaPrev                 <= 1'b1;
      rxPowerHighThreshold    <= '{hi: RESET_BYTE, lo: RESET_BYTE};
      rxPowerLowThreshold     <= '{hi: RESET_BYTE, lo: RESET_BYTE};
      pageChecksum            <= RESET_BYTE;
      temperatureResultHigh   <= RESET_BYTE;
      supplyVoltageResultHigh <= RESET_BYTE;
      rxHighWarning           <= 1'b0;
      rxLowWarning            <= 1'b0;
    end else begin
      state                   <= next_state;
      shiftReg                <= next_shiftReg;
      bitCount                <= next_bitCount;
      offset                  <= next_offset;
      haveOffset              <= next_haveOffset;
      isRead                  <= next_isRead;
      drive                   <= next_drive;
      startPending            <= next_startPending;
      sclPrev                 <= sclLevel;
      sdaPrev                 <= sdaLevel;
      rxPowerHighThreshold    <= next_rxPowerHighThreshold;
      rxPowerLowThreshold     <= next_rxPowerLowThreshold;
      pageChecksum            <= next_pageChecksum;
      temperatureResultHigh   <= next_temperatureResultHigh;
      supplyVoltageResultHigh <= next_supplyVoltageResultHigh;
      rxHighWarning           <= next_rxHighWarning;
      rxLowWarning            <= next_rxLowWarning;
    end
  end
endmodule

// ### rxlt_regs_assertions.sv
// Purpose: Port checks of the register slice
// Assumes: One clock, synchronous active-low reset
// Notes:   Bus bounds assume half periods of 8 clocks or more
`timescale 1ns/1ps
module rxlt_regs_chk
  import rxlt_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic                 sclIn,
  input wire logic                 sdaOe,
  input wire logic [7:0]           rxPowerMeasuredHigh,
  input wire rxlt_pkg::rxlt_pair_t rxPowerHighThreshold,
  input wire rxlt_pkg::rxlt_pair_t rxPowerLowThreshold,
  input wire logic                 rxHighWarning,
  input wire logic                 rxLowWarning
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_high_warn_cmp: assert property (
    $past(reset_n) |->
      rxHighWarning == ($past(rxPowerMeasuredHigh) > $past(rxPowerHighThreshold.hi)))
    else $error("high warning wrong");
  a_low_warn_cmp: assert property (
    $past(reset_n) |->
      rxLowWarning == ($past(rxPowerMeasuredHigh) < $past(rxPowerLowThreshold.hi)))
    else $error("low warning wrong");
  a_reset_zero: assert property (
    $rose(reset_n) |-> rxPowerLowThreshold == 16'h0000 && rxPowerHighThreshold == 16'h0000
      && !sdaOe && !rxLowWarning && !rxHighWarning)
    else $error("not zero after reset");
  a_low_thr_sclk: assert property (
    $changed(rxPowerLowThreshold) |-> !sclIn)
    else $error("low threshold moved with clock high");
  a_high_thr_sclk: assert property (
    $changed(rxPowerHighThreshold) |-> !sclIn)
    else $error("high threshold moved with clock high");
  // Low bytes must never reach the comparisons
  a_lo_ignored: assert property (
    $past(reset_n) && $stable(rxPowerMeasuredHigh) && $stable(rxPowerLowThreshold.hi)
      && $stable(rxPowerHighThreshold.hi) |=> $stable(rxLowWarning) && $stable(rxHighWarning))
    else $error("warning moved without cause");
  a_oe_scl_low: assert property (
    $changed(sdaOe) |-> !sclIn)
    else $error("data line changed with clock high");
  a_ack_held: assert property (
    $rose(sdaOe) |-> sdaOe[*8])
    else $error("pull-down too short");
endmodule

bind rxlt_regs rxlt_regs_chk CHK (.clk_sys(clk_sys), .reset_n(reset_n), .sclIn(sclIn),
  .sdaOe(sdaOe), .rxPowerMeasuredHigh(rxPowerMeasuredHigh),
  .rxPowerHighThreshold(rxPowerHighThreshold), .rxPowerLowThreshold(rxPowerLowThreshold),
  .rxHighWarning(rxHighWarning), .rxLowWarning(rxLowWarning));

// ### rxlt_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to clk_sys
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module rxlt_sync (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      level
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  always_comb begin
    next_level = level;
    // Change only once last two stages agree
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
      level  <= 1'b1;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the register slice
// Assumes: Host model drives the bus, bench drives ADC and rx power
// Notes:   Watchdog cuts a hang at 50000 clocks
`timescale 1ns/1ps
module tb_top;
  import rxlt_pkg::*;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       oemUnlocked = 1'b0;
  // Result bytes busy but not valid: must not load
  rxlt_adc_t  adcResult = 17'h0_7733;
  logic [7:0] rxPowerMeasuredHigh = 8'h00;
  logic       sclIn, sdaIn, sdaOut, sdaOe, rxHighWarning, rxLowWarning, ack;
  rxlt_pair_t rxPowerHighThreshold, rxPowerLowThreshold;
  logic [7:0] rv;
  int         error_cnt = 0;
  int         checks = 0;
  always #5 clk_sys = ~clk_sys;
  rxlt_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .oemUnlocked(oemUnlocked), .adcResult(adcResult),
    .rxPowerMeasuredHigh(rxPowerMeasuredHigh), .rxPowerHighThreshold(rxPowerHighThreshold),
    .rxPowerLowThreshold(rxPowerLowThreshold), .rxHighWarning(rxHighWarning),
    .rxLowWarning(rxLowWarning));
  rxlt_host host (.clk_sys(clk_sys), .sdaOe(sdaOe), .scl(sclIn), .sda(sdaIn));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] off, input logic [7:0] e);
    host.rd(off, rv);
    chk($sformatf("reg %h", off), e, rv);
  endtask
  task automatic wrchk(input logic [7:0] off, input logic [7:0] d);
    host.wr(off, d, ack);
    chk("ack", 1'b1, ack);
  endtask
  task automatic warn(input logic [7:0] m, input logic [1:0] e);
    rxPowerMeasuredHigh = m;
    repeat (3) @(negedge clk_sys);
    chk("warnings", e, {rxHighWarning, rxLowWarning});
  endtask
  task automatic t_reset;
    logic [7:0] offs [7] = '{8'h26, 8'h27, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63};
    foreach (offs[i]) rdchk(offs[i], 8'h00);
  endtask
  task automatic t_addr;
    logic [8:0] r;
    host.start();
    host.xfer({7'h52, 1'b0, 1'b1}, r);
    host.stop();
    chk("foreign address", 1'b1, r[0]);
    chk("sda value", 1'b0, sdaOut);
  endtask
  task automatic t_warn;
    wrchk(OFF_RX_HI_TH_HI, 8'h50);
    wrchk(OFF_RX_HI_TH_LO, 8'h00);
    wrchk(OFF_RX_LO_TH_HI, 8'h40);
    wrchk(OFF_RX_LO_TH_LO, 8'h00);
    rdchk(OFF_RX_LO_TH_HI, 8'h40);
    chk("high pair", 16'h5000, rxPowerHighThreshold);
    warn(8'h3F, 2'b01);
    warn(8'h40, 2'b00);
    warn(8'h50, 2'b00);
    warn(8'h51, 2'b10);
    wrchk(OFF_RX_LO_TH_LO, 8'hFF);
    chk("low pair", 16'h40FF, rxPowerLowThreshold);
    warn(8'h3F, 2'b01);
    wrchk(OFF_RX_LO_TH_LO, 8'h00);
  endtask
  task automatic t_page_checksum;
    wrchk(OFF_CHECKSUM, 8'hA5);
    rdchk(OFF_CHECKSUM, 8'h00);
    oemUnlocked = 1'b1;
    wrchk(OFF_CHECKSUM, 8'hA5);
    oemUnlocked = 1'b0;
    rdchk(OFF_CHECKSUM, 8'hA5);
  endtask
  task automatic t_adc;
    adcResult = {1'b1, 8'h19, 8'h82};
    @(negedge clk_sys);
    adcResult = {1'b0, 8'hEE, 8'hEE};
    rdchk(OFF_TEMP_HI, 8'h19);
    rdchk(OFF_TEMP_LO, 8'h00);
    rdchk(OFF_VOLT_HI, 8'h82);
    wrchk(OFF_TEMP_HI, 8'hFF);
    wrchk(OFF_VOLT_LO, 8'hFF);
    rdchk(OFF_TEMP_HI, 8'h19);
    rdchk(OFF_VOLT_LO, 8'h00);
    rdchk(8'h70, 8'h00);
  endtask
  task automatic t_rereset;
    reset_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("low pair", 16'h0000, rxPowerLowThreshold);
    rdchk(OFF_CHECKSUM, 8'h00);
    rdchk(OFF_TEMP_HI, 8'h00);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_addr();
    t_warn();
    t_page_checksum();
    t_adc();
    t_rereset();
    wrap_up();
  end
  // 28 transfers of 600 to 810 clocks each plus one of 240, some 21000 clocks in all; the limit is over twice that
  initial begin
    repeat (50000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule
